// >>> test/limit_monitor.sv
`timescale 1ns/1ps
module limit_monitor (
  input wire logic                mclk,
  input wire logic                reset,
  input wire limit_pkg::bus_req_t bus_req,
  input wire logic signed [15:0]  pv,
  input wire logic                power_on_restart_select,
  input wire logic                confirm_key,
  input wire logic                first_contact_input,
  input wire logic                rs485_tx,
  input wire logic                rs485_de,
  input wire logic                exceed_lamp,
  input wire logic                trip_lamp,
  input wire logic                relay_energise
);
  // --------------------------------
  // Shadow of limit setup
  // --------------------------------
  logic signed [15:0] sp_q;
  logic               low_q;
  logic               src_q;
  logic [2:0]         age_q;
  logic               beyond;
  logic               conf_pin;

  assign beyond   = low_q ? (pv < sp_q) : (pv > sp_q);
  assign conf_pin = src_q ? first_contact_input : confirm_key;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sp_q  <= 16'sh0000;
      low_q <= 1'b0;
      src_q <= 1'b0;
      age_q <= 3'h0;
    end
    else
    begin
      if (bus_req.wr && bus_req.addr == limit_pkg::SETPOINT_OFF)
        sp_q <= $signed(bus_req.wdata[15:0]);
      if (bus_req.wr && bus_req.addr == limit_pkg::CTRL_OFF)
      begin
        low_q <= bus_req.wdata[limit_pkg::CTRL_LOW_BIT];
        src_q <= bus_req.wdata[limit_pkg::CTRL_SRC_BIT];
      end
      if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_tx_req;
    bus_req.wr && bus_req.addr == limit_pkg::UART_TX_OFF && !rs485_de;
  endsequence
  sequence s_start_bit;
    rs485_de && !rs485_tx;
  endsequence

  property p_exceed_follow;
    age_q != 3'h0 |-> exceed_lamp == $past(beyond);
  endproperty
  a_exceed_follow: assert property (p_exceed_follow) else $error("exceed lamp off");
  property p_trip_set;
    age_q != 3'h0 && $past(beyond) |-> trip_lamp;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not set");
  property p_relay;
    relay_energise != trip_lamp;
  endproperty
  a_relay: assert property (p_relay) else $error("relay not inverse of trip");
  property p_clear_cause;
    $fell(trip_lamp) && age_q == 3'h7 |-> $past(conf_pin, 3) || $past(conf_pin, 4) || $past(conf_pin, 5);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("trip cleared without confirm");
  property p_clear_normal;
    $fell(trip_lamp) |-> !exceed_lamp;
  endproperty
  a_clear_normal: assert property (p_clear_normal) else $error("trip cleared while beyond");
  property p_exceed_off;
    $fell(exceed_lamp) && !$past(conf_pin, 3) |-> trip_lamp;
  endproperty
  a_exceed_off: assert property (p_exceed_off) else $error("trip lost on return");
  property p_tx_start;
    s_tx_req |=> s_start_bit;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  property p_line_idle;
    !rs485_de |-> rs485_tx;
  endproperty
  a_line_idle: assert property (p_line_idle) else $error("line not idle");
  property p_restart;
    $fell(reset) && !power_on_restart_select |=> trip_lamp;
  endproperty
  a_restart: assert property (p_restart) else $error("no trip at restart");
  property p_restart_free;
    $fell(reset) && power_on_restart_select && !beyond |=> !trip_lamp;
  endproperty
  a_restart_free: assert property (p_restart_free) else $error("trip at free restart");
endmodule

bind latching_limit_controller limit_monitor u_limit_monitor (
  .mclk(mclk), .reset(reset), .bus_req(bus_req), .pv(pv), .power_on_restart_select(power_on_restart_select),
  .confirm_key(confirm_key), .first_contact_input(first_contact_input), .rs485_tx(rs485_tx),
  .rs485_de(rs485_de), .exceed_lamp(exceed_lamp), .trip_lamp(trip_lamp), .relay_energise(relay_energise));

// >>> test/process_side_model.sv
`timescale 1ns/1ps
module process_side_model (
  input  wire logic          mclk,
  output logic signed [15:0] pv,
  output logic               confirm_key,
  output logic               first_contact_input,
  output logic               rs485_rx
);
  // --------------------------------
  // Measurement and operator side
  // --------------------------------
  initial
  begin
    rs485_rx            = 1'b1;
    pv                  = 16'sh0000;
    confirm_key         = 1'b0;
    first_contact_input = 1'b0;
  end

  task automatic set_pv(input logic signed [15:0] v);
    @(posedge mclk);
    pv <= v;
  endtask

  // One 8N1 frame, LSB first, line idles at mark
  task automatic send_byte(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      rs485_rx <= f[i];
      repeat (cyc - 1) @(posedge mclk);
    end
  endtask

  // Held past the input synchroniser depth
  task automatic press(input logic contact);
    @(posedge mclk);
    if (contact)
      first_contact_input <= 1'b1;
    else
      confirm_key <= 1'b1;
    repeat (4) @(posedge mclk);
    first_contact_input <= 1'b0;
    confirm_key         <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int BIT_CYC = 128 >> 4;

  logic                               mclk;
  logic                               reset;
  limit_pkg::bus_req_t                bus_req;
  logic [31:0]                        bus_rdata;
  logic signed [15:0]                 pv;
  logic                               power_on_restart_select;
  logic                               confirm_key;
  logic                               first_contact_input;
  logic                               rs485_rx;
  logic                               rs485_tx;
  logic                               rs485_de;
  logic                               exceed_lamp;
  logic                               trip_lamp;
  logic                               relay_energise;
  logic [limit_pkg::NUM_ALARMS-1:0]   alarm_out;
  logic                               irq;
  logic                               rd_seen;
  logic [31:0]                        exp_q[$];
  logic [9:0]                         frame;
  logic signed [15:0]                 sp;
  logic signed [15:0]                 top;
  int                                 mismatches;
  int                                 comparisons;
  int                                 seed;

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  latching_limit_controller #(.TICK_CYCLES(10), .BASE_BIT_CYCLES(128)) u_latching_limit_controller (
    .mclk(mclk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata), .pv(pv),
    .power_on_restart_select(power_on_restart_select), .confirm_key(confirm_key),
    .first_contact_input(first_contact_input), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
    .rs485_de(rs485_de), .exceed_lamp(exceed_lamp), .trip_lamp(trip_lamp),
    .relay_energise(relay_energise), .alarm_out(alarm_out), .irq(irq));

  process_side_model u_process_side_model (
    .mclk(mclk), .pv(pv), .confirm_key(confirm_key),
    .first_contact_input(first_contact_input), .rs485_rx(rs485_rx));

  // --------------------------------
  // Bus, compare and verdict
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk)
    rd_seen <= bus_req.rd;

  always @(negedge mclk)
    if (rd_seen === 1'b1)
      check(bus_rdata, exp_q.pop_front());

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end

  initial
  begin
    seed                    = 35;
    reset                   = 1'b1;
    bus_req                 = '0;
    power_on_restart_select = 1'b0;
    rd_seen                 = 1'b0;
    mismatches              = 0;
    comparisons             = 0;
    settle(5);
    reset <= 1'b0;
    bus_rd(limit_pkg::LIVE_OFF, 32'h2);
    bus_rd(limit_pkg::CTRL_OFF, 32'h10);
    bus_rd(8'h60, 32'h0);
    sp = 16'($random(seed) % 1000);
    bus_wr(limit_pkg::SETPOINT_OFF, {16'h0, sp});
    bus_rd(limit_pkg::SETPOINT_OFF, {16'h0, sp});
    u_process_side_model.set_pv(sp);
    u_process_side_model.press(1'b0);
    bus_rd(limit_pkg::LIVE_OFF, 32'h4);
    bus_wr(limit_pkg::IRQ_MASK_OFF, 32'h1);
    for (int m = 0; m < 2; m++)
    begin
      bus_wr(limit_pkg::CTRL_OFF, 32'h10 | 32'(3 * m));
      bus_wr(limit_pkg::IRQ_STATUS_OFF, 32'hff);
      bus_wr(limit_pkg::MAX_PV_OFF, 32'h0);
      top = m[0] ? sp : sp + 16'sh1;
      u_process_side_model.set_pv(m[0] ? sp - 16'sh1 : sp + 16'sh1);
      settle(3);
      bus_rd(limit_pkg::LIVE_OFF, 32'h3);
      check({31'h0, irq}, 32'h1);
      u_process_side_model.press(m[0]);
      bus_rd(limit_pkg::LIVE_OFF, 32'h3);
      u_process_side_model.set_pv(sp);
      settle(3);
      bus_rd(limit_pkg::LIVE_OFF, 32'h2);
      bus_rd(limit_pkg::MAX_PV_OFF, {{16{top[15]}}, top});
      bus_rd(limit_pkg::IRQ_STATUS_OFF, 32'h3);
      bus_wr(limit_pkg::IRQ_STATUS_OFF, 32'h3);
      bus_rd(limit_pkg::IRQ_STATUS_OFF, 32'h0);
      check({31'h0, irq}, 32'h0);
      u_process_side_model.press(!m[0]);
      bus_rd(limit_pkg::LIVE_OFF, 32'h2);
      u_process_side_model.press(m[0]);
      bus_rd(limit_pkg::LIVE_OFF, 32'h4);
    end
    frame = {1'b1, 8'($random(seed)), 1'b0};
    bus_wr(limit_pkg::UART_TX_OFF, {24'h0, frame[8:1]});
    repeat (BIT_CYC / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      check({31'h0, rs485_tx}, {31'h0, frame[i]});
      repeat (BIT_CYC) @(negedge mclk);
    end
    settle(4);
    check({31'h0, rs485_de}, 32'h0);
    bus_rd(limit_pkg::IRQ_STATUS_OFF, 32'h20);
    u_process_side_model.send_byte(frame[8:1] ^ 8'h5a, BIT_CYC);
    settle(4);
    bus_rd(limit_pkg::UART_RX_OFF, {23'h0, 1'b1, frame[8:1] ^ 8'h5a});
    bus_wr(limit_pkg::ALARM_BASE + limit_pkg::ALARM_SP_OFF, {16'h0, sp});
    bus_wr(limit_pkg::ALARM_BASE, 32'h1);
    u_process_side_model.set_pv(sp + 16'sh1);
    settle(3);
    check({29'h0, alarm_out}, 32'h1);
    u_process_side_model.set_pv(sp);
    settle(3);
    check({29'h0, alarm_out}, 32'h0);
    power_on_restart_select <= 1'b1;
    u_process_side_model.set_pv(-16'sd5);
    reset <= 1'b1;
    settle(5);
    reset <= 1'b0;
    bus_rd(limit_pkg::LIVE_OFF, 32'h4);
    settle(2);
    results();
  end
endmodule

// >>> verilog/latching_limit_controller.sv
// Function
// - High or low limit, one setpoint.
// - Beyond setpoint: exceed on, trip set, relay off.
// - Back to normal clears exceed, trip stays.
// - Trip clears only on operator confirm, or at restart with restart select set and pv not beyond.
// - Confirm from key or contact, selectable.
// - Confirm ignored while still beyond setpoint.
// - Relay de-energised whenever trip is set.
// - Contact confirm uses first contact input only.
// - Three alarms: standby, latch, hysteresis, delays.
// - Accumulate exceed time; retain maximum value.
// - Half-duplex async serial, 600 to 38400 bps.
// - Restart select decides power-on trip state.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module latching_limit_controller #(
  parameter int TICK_CYCLES     = limit_pkg::TICK_CYCLES,
  parameter int BASE_BIT_CYCLES = limit_pkg::BASE_BIT_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire limit_pkg::bus_req_t      bus_req,
  output logic [31:0]                   bus_rdata,
  input  wire logic signed [15:0]       pv,
  input  wire logic                     power_on_restart_select,
  input  wire logic                     confirm_key,
  input  wire logic                     first_contact_input,
  input  wire logic                     rs485_rx,
  output logic                          rs485_tx,
  output logic                          rs485_de,
  output logic                          exceed_lamp,
  output logic                          trip_lamp,
  output logic                          relay_energise,
  output logic [limit_pkg::NUM_ALARMS-1:0] alarm_out,
  output logic                          irq
);

  typedef struct packed {
    logic                    first;
    logic                    trip;
    logic                    exceed;
    logic                    relay;
    logic                    low_mode;
    logic                    confirm_source_select;
    logic [2:0]              baud_sel;
    logic signed [15:0]      sp;
    logic [2:0]              key_sync;
    logic [2:0]              ctc_sync;
    logic [1:0]              rx_sync;
    logic [15:0]             tick_cnt;
    logic [31:0]             exceed_time;
    logic signed [15:0]      max_pv;
    logic                    max_valid;
    logic [7:0]              irq_status;
    logic [7:0]              irq_mask;
    limit_pkg::alarm_cfg_t [limit_pkg::NUM_ALARMS-1:0] acfg;
    limit_pkg::alarm_st_t  [limit_pkg::NUM_ALARMS-1:0] ast;
    logic                    tx_busy;
    logic [9:0]              tx_shift;
    logic [3:0]              tx_bits;
    logic [16:0]             tx_cnt;
    logic                    tx_out;
    logic                    tx_de;
    logic                    rx_busy;
    logic [3:0]              rx_bits;
    logic [16:0]             rx_cnt;
    logic [7:0]              rx_shift;
    logic [7:0]              rx_data;
    logic                    rx_valid;
    logic [31:0]             rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic beyond(input logic signed [17:0] v, input logic signed [17:0] lim,
                                  input logic low);
    return low ? (v < lim) : (v > lim);
  endfunction

  function automatic logic [16:0] bit_cycles(input logic [2:0] sel);
    logic [16:0] base;
    base = 17'(BASE_BIT_CYCLES);
    if (sel > 3'(limit_pkg::BAUD_SEL_MAX))
      return base >> limit_pkg::BAUD_SEL_MAX;
    return base >> sel;
  endfunction

  function automatic logic [7:0] alarm_addr(input int idx, input logic [7:0] off);
    return 8'(limit_pkg::ALARM_BASE + 8'(idx) * limit_pkg::ALARM_STRIDE + off);
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic                    tick;
    logic                    beyond_now;
    logic                    confirm_edge;
    logic [7:0]              ev;
    logic [7:0]              w1c;
    logic [31:0]             rd_val;
    logic signed [17:0]      lim;
    logic                    cond;
    logic [15:0]             dly;
    logic                    wr;
    logic                    rd;
    logic [16:0]             period;
    tick         = 1'b0;
    beyond_now   = 1'b0;
    confirm_edge = 1'b0;
    ev           = 8'h00;
    w1c          = 8'h00;
    rd_val       = 32'h0000_0000;
    lim          = 18'sh00000;
    cond         = 1'b0;
    dly          = 16'h0000;
    wr           = bus_req.wr;
    rd           = bus_req.rd;
    period       = bit_cycles(s_q.baud_sel);
    s_d          = s_q;

    // Pin synchronisers
    s_d.key_sync = {s_q.key_sync[1:0], confirm_key};
    s_d.ctc_sync = {s_q.ctc_sync[1:0], first_contact_input};
    s_d.rx_sync  = {s_q.rx_sync[0], rs485_rx};

    // Millisecond tick
    if (s_q.tick_cnt == 16'(TICK_CYCLES - 1))
    begin
      tick       = 1'b1;
      s_d.tick_cnt = 16'h0000;
    end
    else
      s_d.tick_cnt = s_q.tick_cnt + 16'h0001;

    // Limit supervision
    beyond_now = beyond(18'(pv), 18'(s_q.sp), s_q.low_mode);
    s_d.exceed = beyond_now;
    if (s_q.confirm_source_select)
      confirm_edge = s_q.ctc_sync[1] & ~s_q.ctc_sync[2];
    else
      confirm_edge = s_q.key_sync[1] & ~s_q.key_sync[2];
    s_d.first = 1'b0;
    if (s_q.first)
      s_d.trip = (power_on_restart_select == 1'b0) ? 1'b1 : beyond_now;
    else if (beyond_now)
      s_d.trip = 1'b1;
    else if (confirm_edge)
      s_d.trip = 1'b0;
    s_d.relay = ~s_d.trip;
    ev[limit_pkg::IRQ_TRIP_BIT]   = s_d.trip & ~s_q.trip;
    ev[limit_pkg::IRQ_NORMAL_BIT] = s_q.exceed & ~beyond_now;

    // Exceed time and maximum value
    if (wr && bus_req.addr == limit_pkg::EXCEED_TIME_OFF)
      s_d.exceed_time = 32'h0000_0000;
    if (s_q.exceed && tick)
      s_d.exceed_time = s_d.exceed_time + 32'h0000_0001;
    if (wr && bus_req.addr == limit_pkg::MAX_PV_OFF)
      s_d.max_valid = 1'b0;
    else if (!s_q.max_valid || pv > s_q.max_pv)
    begin
      s_d.max_pv    = pv;
      s_d.max_valid = 1'b1;
    end

    // Alarms
    for (int i = 0; i < limit_pkg::NUM_ALARMS; i++)
    begin
      if (s_q.ast[i].state)
        lim = s_q.acfg[i].low ? 18'(s_q.acfg[i].sp) + $signed({2'b00, s_q.acfg[i].hyst})
                              : 18'(s_q.acfg[i].sp) - $signed({2'b00, s_q.acfg[i].hyst});
      else
        lim = 18'(s_q.acfg[i].sp);
      cond = s_q.acfg[i].enable & beyond(18'(pv), lim, s_q.acfg[i].low);
      dly  = cond ? s_q.acfg[i].on_dly : s_q.acfg[i].off_dly;
      if (cond == s_q.ast[i].state)
        s_d.ast[i].dly_cnt = 16'h0000;
      else if (s_q.ast[i].dly_cnt >= dly)
      begin
        s_d.ast[i].state   = cond;
        s_d.ast[i].dly_cnt = 16'h0000;
      end
      else if (tick)
        s_d.ast[i].dly_cnt = s_q.ast[i].dly_cnt + 16'h0001;
      if (!s_q.acfg[i].standby || !s_q.ast[i].state)
        s_d.ast[i].armed = 1'b1;
      if (wr && bus_req.addr == limit_pkg::ALARM_RESET_OFF && bus_req.wdata[i])
        s_d.ast[i].latched = 1'b0;
      if (s_q.acfg[i].latch && s_q.ast[i].state && s_q.ast[i].armed)
        s_d.ast[i].latched = 1'b1;
      s_d.ast[i].out = s_q.ast[i].armed &
                       (s_q.acfg[i].latch ? (s_q.ast[i].latched | s_q.ast[i].state) : s_q.ast[i].state);
      ev[limit_pkg::IRQ_ALARM_LSB + i] = s_d.ast[i].out & ~s_q.ast[i].out;
      if (wr && bus_req.addr == alarm_addr(i, limit_pkg::ALARM_CFG_OFF))
      begin
        s_d.acfg[i].enable  = bus_req.wdata[limit_pkg::ACFG_EN_BIT];
        s_d.acfg[i].low     = bus_req.wdata[limit_pkg::ACFG_LOW_BIT];
        s_d.acfg[i].standby = bus_req.wdata[limit_pkg::ACFG_STBY_BIT];
        s_d.acfg[i].latch   = bus_req.wdata[limit_pkg::ACFG_LATCH_BIT];
        s_d.ast[i].armed    = ~bus_req.wdata[limit_pkg::ACFG_STBY_BIT];
      end
      if (wr && bus_req.addr == alarm_addr(i, limit_pkg::ALARM_SP_OFF))
        s_d.acfg[i].sp = bus_req.wdata[15:0];
      if (wr && bus_req.addr == alarm_addr(i, limit_pkg::ALARM_HYST_OFF))
        s_d.acfg[i].hyst = bus_req.wdata[15:0];
      if (wr && bus_req.addr == alarm_addr(i, limit_pkg::ALARM_DLY_OFF))
      begin
        s_d.acfg[i].on_dly  = bus_req.wdata[15:0];
        s_d.acfg[i].off_dly = bus_req.wdata[31:16];
      end
      if (bus_req.addr == alarm_addr(i, limit_pkg::ALARM_CFG_OFF))
        rd_val = {28'h0000000, s_q.acfg[i].latch, s_q.acfg[i].standby, s_q.acfg[i].low, s_q.acfg[i].enable};
      if (bus_req.addr == alarm_addr(i, limit_pkg::ALARM_SP_OFF))
        rd_val = {16'h0000, s_q.acfg[i].sp};
      if (bus_req.addr == alarm_addr(i, limit_pkg::ALARM_HYST_OFF))
        rd_val = {16'h0000, s_q.acfg[i].hyst};
      if (bus_req.addr == alarm_addr(i, limit_pkg::ALARM_DLY_OFF))
        rd_val = {s_q.acfg[i].off_dly, s_q.acfg[i].on_dly};
    end

    // Serial transmitter, drives the line only while busy
    if (s_q.tx_busy)
    begin
      if (s_q.tx_cnt == 17'h00000)
      begin
        if (s_q.tx_bits == 4'h1)
        begin
          s_d.tx_busy = 1'b0;
          ev[limit_pkg::IRQ_TX_DONE_BIT] = 1'b1;
        end
        else
        begin
          s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]};
          s_d.tx_bits  = s_q.tx_bits - 4'h1;
          s_d.tx_cnt   = period - 17'h00001;
        end
      end
      else
        s_d.tx_cnt = s_q.tx_cnt - 17'h00001;
    end
    else if (wr && bus_req.addr == limit_pkg::UART_TX_OFF)
    begin
      s_d.tx_busy  = 1'b1;
      s_d.tx_shift = {1'b1, bus_req.wdata[7:0], 1'b0};
      s_d.tx_bits  = 4'(limit_pkg::FRAME_BITS);
      s_d.tx_cnt   = period - 17'h00001;
    end
    s_d.tx_out = ~s_d.tx_busy | s_d.tx_shift[0];
    s_d.tx_de  = s_d.tx_busy;

    // Serial receiver, deaf while transmitting
    if (rd && bus_req.addr == limit_pkg::UART_RX_OFF)
      s_d.rx_valid = 1'b0;
    if (!s_q.rx_busy)
    begin
      if (!s_q.tx_busy && !s_q.rx_sync[1])
      begin
        s_d.rx_busy = 1'b1;
        s_d.rx_bits = 4'h0;
        s_d.rx_cnt  = (period >> 1) - 17'h00001;
      end
    end
    else if (s_q.rx_cnt != 17'h00000)
      s_d.rx_cnt = s_q.rx_cnt - 17'h00001;
    else if (s_q.rx_bits == 4'h0)
    begin
      s_d.rx_busy = ~s_q.rx_sync[1];
      s_d.rx_bits = 4'h1;
      s_d.rx_cnt  = period - 17'h00001;
    end
    else if (s_q.rx_bits != 4'(limit_pkg::FRAME_BITS - 1))
    begin
      s_d.rx_shift = {s_q.rx_sync[1], s_q.rx_shift[7:1]};
      s_d.rx_bits  = s_q.rx_bits + 4'h1;
      s_d.rx_cnt   = period - 17'h00001;
    end
    else
    begin
      s_d.rx_busy = 1'b0;
      if (s_q.rx_sync[1])
      begin
        s_d.rx_data  = s_q.rx_shift;
        s_d.rx_valid = 1'b1;
        ev[limit_pkg::IRQ_RX_BYTE_BIT] = 1'b1;
      end
      else
        ev[limit_pkg::IRQ_RX_FERR_BIT] = 1'b1;
    end

    // Register writes
    if (wr)
    begin
      unique case (bus_req.addr)
        limit_pkg::CTRL_OFF:
        begin
          s_d.low_mode              = bus_req.wdata[limit_pkg::CTRL_LOW_BIT];
          s_d.confirm_source_select = bus_req.wdata[limit_pkg::CTRL_SRC_BIT];
          s_d.baud_sel              = bus_req.wdata[limit_pkg::CTRL_BAUD_LSB +: 3];
        end
        limit_pkg::SETPOINT_OFF:   s_d.sp       = bus_req.wdata[15:0];
        limit_pkg::IRQ_STATUS_OFF: w1c          = bus_req.wdata[7:0];
        limit_pkg::IRQ_MASK_OFF:   s_d.irq_mask = bus_req.wdata[7:0];
        default: ;
      endcase
    end
    s_d.irq_status = (s_q.irq_status & ~w1c) | ev;

    // Register reads, data valid in the following cycle only
    unique case (bus_req.addr)
      limit_pkg::CTRL_OFF:
        rd_val = {27'h0000000, s_q.baud_sel, s_q.confirm_source_select, s_q.low_mode};
      limit_pkg::SETPOINT_OFF:    rd_val = {16'h0000, s_q.sp};
      limit_pkg::LIVE_OFF:
        rd_val = {24'h000000, s_q.rx_valid, s_q.tx_busy, s_q.ast[2].out, s_q.ast[1].out, s_q.ast[0].out,
                  s_q.relay, s_q.trip, s_q.exceed};
      limit_pkg::IRQ_STATUS_OFF:  rd_val = {24'h000000, s_q.irq_status};
      limit_pkg::IRQ_MASK_OFF:    rd_val = {24'h000000, s_q.irq_mask};
      limit_pkg::EXCEED_TIME_OFF: rd_val = s_q.exceed_time;
      limit_pkg::MAX_PV_OFF:      rd_val = {{16{s_q.max_pv[15]}}, s_q.max_pv};
      limit_pkg::UART_RX_OFF:     rd_val = {23'h000000, s_q.rx_valid, s_q.rx_data};
      default: ;
    endcase
    s_d.rdata = rd ? rd_val : 32'h0000_0000;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q          <= '0;
      s_q.first    <= 1'b1;
      s_q.trip     <= limit_pkg::TRIP_RST;
      s_q.baud_sel <= limit_pkg::BAUD_SEL_RST;
      s_q.sp       <= limit_pkg::SETPOINT_RST;
      s_q.irq_mask <= limit_pkg::IRQ_MASK_RST;
      s_q.key_sync <= 3'h7;
      s_q.ctc_sync <= 3'h7;
      s_q.rx_sync  <= 2'h3;
      s_q.tx_out   <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  always_comb
  begin
    bus_rdata      = s_q.rdata;
    rs485_tx       = s_q.tx_out;
    rs485_de       = s_q.tx_de;
    exceed_lamp    = s_q.exceed;
    trip_lamp      = s_q.trip;
    relay_energise = s_q.relay;
    for (int i = 0; i < limit_pkg::NUM_ALARMS; i++)
      alarm_out[i] = s_q.ast[i].out;
    irq = |(s_q.irq_status & s_q.irq_mask);
  end

endmodule

// >>> verilog/limit_pkg.sv
package limit_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int BASE_BAUD_BPS   = 600;
  localparam int BASE_BIT_CYCLES = CLK_HZ / BASE_BAUD_BPS;
  localparam int BAUD_SEL_MAX    = 6;
  localparam int FRAME_BITS      = 10;
  localparam int NUM_ALARMS      = 3;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF        = 8'h00;
  localparam logic [7:0] SETPOINT_OFF    = 8'h04;
  localparam logic [7:0] LIVE_OFF        = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFF  = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFF    = 8'h10;
  localparam logic [7:0] EXCEED_TIME_OFF = 8'h14;
  localparam logic [7:0] MAX_PV_OFF      = 8'h18;
  localparam logic [7:0] ALARM_RESET_OFF = 8'h1c;
  localparam logic [7:0] ALARM_BASE      = 8'h20;
  localparam logic [7:0] ALARM_STRIDE    = 8'h10;
  localparam logic [7:0] ALARM_CFG_OFF   = 8'h00;
  localparam logic [7:0] ALARM_SP_OFF    = 8'h04;
  localparam logic [7:0] ALARM_HYST_OFF  = 8'h08;
  localparam logic [7:0] ALARM_DLY_OFF   = 8'h0c;
  localparam logic [7:0] UART_TX_OFF     = 8'h50;
  localparam logic [7:0] UART_RX_OFF     = 8'h54;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_LOW_BIT     = 0;
  localparam int CTRL_SRC_BIT     = 1;
  localparam int CTRL_BAUD_LSB    = 2;
  localparam int ACFG_EN_BIT      = 0;
  localparam int ACFG_LOW_BIT     = 1;
  localparam int ACFG_STBY_BIT    = 2;
  localparam int ACFG_LATCH_BIT   = 3;
  localparam int IRQ_TRIP_BIT     = 0;
  localparam int IRQ_NORMAL_BIT   = 1;
  localparam int IRQ_ALARM_LSB    = 2;
  localparam int IRQ_TX_DONE_BIT  = 5;
  localparam int IRQ_RX_BYTE_BIT  = 6;
  localparam int IRQ_RX_FERR_BIT  = 7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  BAUD_SEL_RST = 3'h4;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic        TRIP_RST     = 1'b1;
  localparam logic [7:0]  IRQ_MASK_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic              enable;
    logic              low;
    logic              standby;
    logic              latch;
    logic signed [15:0] sp;
    logic [15:0]       hyst;
    logic [15:0]       on_dly;
    logic [15:0]       off_dly;
  } alarm_cfg_t;

  typedef struct packed {
    logic        state;
    logic        armed;
    logic        latched;
    logic        out;
    logic [15:0] dly_cnt;
  } alarm_st_t;

endpackage
